/* verilog/gpio_pin_controller.sv */
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_controller_defines.svh"

module gpio_pin_controller
  import gpio_pin_controller_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] pin_in,
  output pad_ctrl_s pad,
  input wire logic [5:0] indicator_enable_strap,
  input wire logic [5:0] indicator_level,
  output logic system_irq
);

  pin_cfg_s cfg_reg;
  pin_cfg_s cfg_next;
  logic [7:0] irq_status_reg;
  logic [7:0] irq_status_next;
  logic [5:0] indicator_enable_reg;
  logic [5:0] indicator_enable_next;
  logic strap_taken_reg;
  logic [7:0] sync1_reg;
  logic [7:0] sync2_reg;
  logic aw_held_reg;
  logic w_held_reg;
  logic [11:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  filter_cnt_t filt_cnt_reg [8];

  wire [7:0] pin_active;
  wire [7:0] level_hit;
  wire [7:0] ind_mask;
  wire [7:0] lo_mask;
  wire [7:0] hi_mask;
  wire [7:0] w_lo;
  wire [7:0] w_hi;
  wire [7:0] sts_clear;
  wire [7:0] data_view;
  wire do_write;
  wire wr_dd;
  wire wr_cfg;
  wire wr_sts;
  wire wr_ind;
  wire wr_hit;
  wire rd_take;
  wire rd_dd;
  wire rd_cfg;
  wire rd_sts;
  wire rd_ind;
  wire [31:0] rd_mux;

  // Bus handshakes; one write and one read in flight at most
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign do_write = aw_held_reg && w_held_reg;
  assign rd_take = s_axi_arvalid && !rvalid_reg;

  // Write decode and byte lane masks
  assign wr_dd = do_write && (aw_addr_reg == `OFF_DATA_DIR);
  assign wr_cfg = do_write && (aw_addr_reg == `OFF_CFG);
  assign wr_sts = do_write && (aw_addr_reg == `OFF_IRQ_STS_EN);
  assign wr_ind = do_write && (aw_addr_reg == `OFF_INDICATOR);
  assign wr_hit = wr_dd || wr_cfg || wr_sts || wr_ind;
  assign lo_mask = {8{w_strb_reg[0]}};
  assign hi_mask = {8{w_strb_reg[1]}};
  assign w_lo = w_data_reg[`FLD_LOW_LSB +: 8];
  assign w_hi = w_data_reg[`FLD_HIGH_LSB +: 8];
  assign sts_clear = wr_sts ? (w_lo & lo_mask) : `RST_BYTE;

  // Register next values, byte lanes honoured
  always_comb begin
    cfg_next = cfg_reg;
    indicator_enable_next = indicator_enable_reg;
    if (wr_dd) begin
      cfg_next.pin_data = (cfg_reg.pin_data & ~lo_mask) | (w_lo & lo_mask);
      cfg_next.pin_direction =
        (cfg_reg.pin_direction & ~hi_mask) | (w_hi & hi_mask);
    end
    if (wr_cfg) begin
      cfg_next.pin_buffer_type =
        (cfg_reg.pin_buffer_type & ~lo_mask) | (w_lo & lo_mask);
      cfg_next.pin_irq_polarity =
        (cfg_reg.pin_irq_polarity & ~hi_mask) | (w_hi & hi_mask);
    end
    if (wr_sts) begin
      cfg_next.pin_irq_enable =
        (cfg_reg.pin_irq_enable & ~hi_mask) | (w_hi & hi_mask);
    end
    if (!strap_taken_reg) begin
      indicator_enable_next = indicator_enable_strap;
    end else if (wr_ind && w_strb_reg[0]) begin
      indicator_enable_next = w_lo[5:0];
    end
  end

  // Configuration registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg <= '0;
      indicator_enable_reg <= `RST_INDICATOR;
      strap_taken_reg <= 1'b0;
    end else begin
      cfg_reg <= cfg_next;
      indicator_enable_reg <= indicator_enable_next;
      strap_taken_reg <= 1'b1;
    end
  end

  // Two-flop input synchroniser
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= `RST_BYTE;
      sync2_reg <= `RST_BYTE;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Active level per pin from its polarity bit
  assign pin_active =
    ~(sync2_reg ^ cfg_reg.pin_irq_polarity);

  // Per-pin level filter: active level must persist the minimum time
  genvar gi;
  generate
    for (gi = 0; gi < `PIN_COUNT; gi++) begin : g_filt
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          filt_cnt_reg[gi] <= '0;
        end else if (!pin_active[gi]) begin
          filt_cnt_reg[gi] <= '0;
        end else if (!level_hit[gi]) begin
          filt_cnt_reg[gi] <= filt_cnt_reg[gi] + 3'h1;
        end
      end
      assign level_hit[gi] =
        (filt_cnt_reg[gi] == 3'(`IRQ_FILTER_CYCLES));
    end
  endgenerate

  // Sticky status; a new hit beats a clear in the same cycle
  assign irq_status_next = (irq_status_reg & ~sts_clear) | level_hit;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status_reg <= `RST_BYTE;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  // Single aggregated request
  assign system_irq = |(irq_status_reg & cfg_reg.pin_irq_enable);

  // Pad drive: indicator, push-pull or open-drain
  assign ind_mask = {2'h0, indicator_enable_reg};
  generate
    for (gi = 0; gi < `PIN_COUNT; gi++) begin : g_pad
      if (gi < `INDICATOR_COUNT) begin : g_ind
        assign pad.out[gi] = ind_mask[gi] ? indicator_level[gi] :
          (!cfg_reg.pin_buffer_type[gi] && cfg_reg.pin_data[gi]);
      end else begin : g_gp
        assign pad.out[gi] =
          !cfg_reg.pin_buffer_type[gi] && cfg_reg.pin_data[gi];
      end
      // Open-drain floats on a 1, push-pull drives whenever the direction bit is set
      assign pad.oe[gi] = ind_mask[gi] || (cfg_reg.pin_direction[gi] &&
        (!cfg_reg.pin_buffer_type[gi] ||
        !cfg_reg.pin_data[gi]));
    end
  endgenerate
  assign pad.in_enable = ~cfg_reg.pin_direction & ~ind_mask;
  assign pad.pullup_enable = ~ind_mask;

  // Read decode
  assign data_view = (cfg_reg.pin_direction & cfg_reg.pin_data) |
    (~cfg_reg.pin_direction & sync2_reg);
  assign rd_dd = s_axi_araddr == `OFF_DATA_DIR;
  assign rd_cfg = s_axi_araddr == `OFF_CFG;
  assign rd_sts = s_axi_araddr == `OFF_IRQ_STS_EN;
  assign rd_ind = s_axi_araddr == `OFF_INDICATOR;
  assign rd_mux =
    rd_dd ? {16'h0000, cfg_reg.pin_direction, data_view} :
    rd_cfg ? {16'h0000, cfg_reg.pin_irq_polarity, cfg_reg.pin_buffer_type} :
    rd_sts ? {16'h0000, cfg_reg.pin_irq_enable, irq_status_reg} :
    rd_ind ? {23'h000000, system_irq, 2'h0, indicator_enable_reg} :
    32'h00000000;

  // Write channel capture and response
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Read channel
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= `RESP_OKAY;
    end else if (rd_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_mux;
      rresp_reg <= (rd_dd || rd_cfg || rd_sts || rd_ind) ?
        `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_first_cycle;
    !$past(reset_n);
  endsequence

  AST_RESET_DIR: assert property (s_first_cycle |->
    cfg_reg.pin_direction == 8'h00) else $error("direction not cleared");
  AST_RESET_EN: assert property (s_first_cycle |->
    cfg_reg.pin_irq_enable == 8'h00 && !system_irq)
    else $error("irq enable not cleared");
  AST_RESET_POL: assert property (s_first_cycle |->
    cfg_reg.pin_irq_polarity == 8'h00) else $error("polarity not cleared");
  AST_STRAP: assert property (!$past(strap_taken_reg) &&
    strap_taken_reg |-> indicator_enable_reg == $past(indicator_enable_strap))
    else $error("strap not captured");
  AST_SYNC: assert property ($past(reset_n) && $past(reset_n, 2)
    |-> sync2_reg == $past(pin_in, 2))
    else $error("synchroniser depth wrong");
  AST_IRQ_AGG: assert property (
    (irq_status_reg & cfg_reg.pin_irq_enable) != 8'h00 |-> system_irq)
    else $error("request missing");
  AST_IN_BUF: assert property (|(pad.in_enable &
    (cfg_reg.pin_direction | ind_mask)) == 1'b0)
    else $error("input buffer on for driven pin");
  AST_READBACK: assert property (rd_take && rd_dd &&
    cfg_reg.pin_direction == 8'h00 |=> s_axi_rdata[7:0] == $past(sync2_reg))
    else $error("input readback wrong");

  generate
    for (gi = 0; gi < `PIN_COUNT; gi++) begin : g_chk
      sequence s_held_active;
        pin_active[gi] [*5];
      endsequence
      AST_LEVEL_SET: assert property (s_held_active |=> ##1
        irq_status_reg[gi]) else $error("held level not latched");
      AST_NO_SHORT: assert property ($rose(irq_status_reg[gi]) |->
        $past(pin_active[gi], 2) && $past(pin_active[gi], 6))
        else $error("status set by short pulse");
      AST_STICKY: assert property (irq_status_reg[gi] &&
        !sts_clear[gi] |=> irq_status_reg[gi]) else $error("status dropped");
      AST_OD: assert property (cfg_reg.pin_direction[gi] &&
        cfg_reg.pin_buffer_type[gi] && !ind_mask[gi] |->
        !pad.out[gi] && pad.oe[gi] == !cfg_reg.pin_data[gi])
        else $error("open-drain drive wrong");
      AST_PP: assert property (cfg_reg.pin_direction[gi] &&
        !cfg_reg.pin_buffer_type[gi] && !ind_mask[gi] |->
        pad.oe[gi] && pad.out[gi] == cfg_reg.pin_data[gi])
        else $error("push-pull drive wrong");
    end
  endgenerate

endmodule
`default_nettype wire

/* verilog/gpio_pin_controller_defines.svh */
// Summary of operation
// - Eight pins: input, push-pull, open-drain, interrupting.
// - Reset clears all direction bits: inputs.
// - Reset clears all pin interrupt enables.
// - Reset clears polarity: low level triggers.
// - Straps may make pins 5..0 indicators.
// - Buffer type bit picks push-pull or open-drain.
// - Open-drain drives low on 0, floats on 1.
// - Push-pull drives the data bit value.
// - Input pin data bit reads pin level.
// - Output pin: input buffer off, pull-up on.
// - Per-pin status and enable; status readable.
// - Enabled statuses ORed into one system request.
// - Level interrupts need more than 40 ns.
// - Polarity set: high level sets status.
// - Polarity clear: low level sets status.
// - Indicator pin: input buffer and pull-up off.
`ifndef GPIO_PIN_CONTROLLER_DEFINES_SVH
`define GPIO_PIN_CONTROLLER_DEFINES_SVH

`define PIN_COUNT 8
`define INDICATOR_COUNT 6
`define ADDR_WIDTH 12

// Register byte offsets
`define OFF_DATA_DIR 12'h000
`define OFF_CFG 12'h004
`define OFF_IRQ_STS_EN 12'h008
`define OFF_INDICATOR 12'h00c

// Field positions
`define FLD_LOW_LSB 0
`define FLD_HIGH_LSB 8
`define FLD_SYS_IRQ_BIT 8

// Reset values
`define RST_BYTE 8'h00
`define RST_INDICATOR 6'h00

// Bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// Interrupt level filter timing
`define CLK_PERIOD_NS 8
`define IRQ_MIN_ACTIVE_NS 40
`define IRQ_FILTER_CYCLES \
  ((`IRQ_MIN_ACTIVE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* verilog/gpio_pin_controller_pkg.sv */
`default_nettype none
package gpio_pin_controller_pkg;

  // Per-pin software configuration, one bit per pin in each field
  typedef struct packed {
    logic [7:0] pin_direction;
    logic [7:0] pin_buffer_type;
    logic [7:0] pin_data;
    logic [7:0] pin_irq_polarity;
    logic [7:0] pin_irq_enable;
  } pin_cfg_s;

  // Pad-facing controls for the eight pins
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] in_enable;
    logic [7:0] pullup_enable;
  } pad_ctrl_s;

  typedef logic [2:0] filter_cnt_t;

endpackage
`default_nettype wire

/* tb/pin_circuits.sv */
`timescale 1ns/1ps
`default_nettype none

module pin_circuits
  import gpio_pin_controller_pkg::*;
(
  input wire logic clk,
  input wire pad_ctrl_s pad,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_level,
  output logic [7:0] pin_level
);
  logic [7:0] float_reg = 8'h00;

  // Undriven pin without pull-up wanders
  always @(posedge clk) begin
    float_reg <= ~float_reg;
  end

  // Device drive wins, else external circuit, else pull-up
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad.oe[i])
        pin_level[i] = pad.out[i];
      else if (ext_en[i])
        pin_level[i] = ext_level[i];
      else if (pad.pullup_enable[i])
        pin_level[i] = 1'b1;
      else
        pin_level[i] = float_reg[i];
    end
  end
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import gpio_pin_controller_pkg::*;
  logic clk = 0, reset_n = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, system_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [7:0] pin_in, ext_en = 0, ext_level = 0;
  pad_ctrl_s pad;
  logic [5:0] indicator_enable_strap = 6'h21, indicator_level = 6'h3f;
  int mismatches = 0, samples_checked = 0;

  always #4 clk = ~clk;

  gpio_pin_controller dut_u (.clk, .reset_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in,
    .pad, .indicator_enable_strap, .indicator_level, .system_irq);

  pin_circuits far_u (.clk, .pad, .ext_en, .ext_level,
    .pin_level(pin_in));

  task chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Write with address and data offered together
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    b = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!b) begin
      @(negedge clk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge clk);
      if (aw) s_axi_awvalid <= 0;
      if (w) s_axi_wvalid <= 0;
    end
    s_axi_bready <= 0;
    chk("bresp", {30'h0, r}, {30'h0, er});
  endtask

  // Read and compare data and response
  task automatic rd(input logic [11:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    logic ar, v;
    logic [31:0] d;
    logic [1:0] r;
    v = 0;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    while (!v) begin
      @(negedge clk);
      ar = s_axi_arvalid && s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk);
      if (ar) s_axi_arvalid <= 0;
    end
    s_axi_rready <= 0;
    chk("rresp", {30'h0, r}, {30'h0, er});
    chk("rdata", d, ed);
  endtask

  task automatic reset_and_straps();
    chk("pad", pad, {8'h21, 8'h21, 8'hde, 8'hde});
    rd(12'h000, 32'h0000_00ff, 2'b00);
    rd(12'h004, 32'h0, 2'b00);
    rd(12'h008, 32'h0, 2'b00);
    wr(12'h008, 32'h0000_00ff, 2'b00);
    rd(12'h008, 32'h0, 2'b00);
    rd(12'h00c, 32'h21, 2'b00);
    wr(12'h00c, 32'h0, 2'b00);
  endtask

  task automatic outputs();
    wr(12'h000, 32'h0000_ffa5, 2'b00);
    chk("pushpull", pad, {8'ha5, 8'hff, 8'h00, 8'hff});
    wr(12'h004, 32'h0000_00ff, 2'b00);
    chk("opendrain", pad, {8'h00, 8'h5a, 8'h00, 8'hff});
    rd(12'h000, 32'h0000_ffa5, 2'b00);
  endtask

  task automatic inputs();
    wr(12'h000, 32'h0, 2'b00);
    wr(12'h004, 32'h0, 2'b00);
    ext_en <= 8'hff;
    ext_level <= 8'h3c;
    repeat (4) @(posedge clk);
    chk("inpad", pad, {8'h00, 8'h00, 8'hff, 8'hff});
    rd(12'h000, 32'h3c, 2'b00);
  endtask

  task automatic irqs();
    ext_level <= 8'h0f;
    wr(12'h004, 32'h0000_f000, 2'b00);
    repeat (10) @(posedge clk);
    wr(12'h008, 32'h0000_00ff, 2'b00);
    rd(12'h008, 32'h0, 2'b00);
    ext_level <= 8'h8f;
    repeat (3) @(posedge clk);
    ext_level <= 8'h0f;
    repeat (10) @(posedge clk);
    rd(12'h008, 32'h0, 2'b00);
    ext_level <= 8'h3c;
    repeat (10) @(posedge clk);
    rd(12'h008, 32'h33, 2'b00);
    chk("irq_off", {31'h0, system_irq}, 32'h0);
    wr(12'h008, 32'h0000_0200, 2'b00);
    ext_level <= 8'h0f;
    repeat (10) @(posedge clk);
    rd(12'h008, 32'h233, 2'b00);
    chk("irq_on", {31'h0, system_irq}, 32'h1);
    rd(12'h00c, 32'h100, 2'b00);
    wr(12'h008, 32'h0000_02ff, 2'b00);
    rd(12'h008, 32'h200, 2'b00);
    chk("irq_clr", {31'h0, system_irq}, 32'h0);
  endtask

  // Byte lanes: each strobe guards its own field
  task automatic lanes();
    s_axi_wstrb <= 4'h1;
    wr(12'h000, 32'h0000_ff5a, 2'b00);
    rd(12'h000, 32'h0000_000f, 2'b00);
    s_axi_wstrb <= 4'h2;
    wr(12'h000, 32'h0000_ff00, 2'b00);
    s_axi_wstrb <= 4'hf;
    chk("lanes", pad, {8'h5a, 8'hff, 8'h00, 8'hff});
    rd(12'h000, 32'h0000_ff5a, 2'b00);
  endtask

  task automatic unmapped();
    wr(12'h010, 32'hffff_ffff, 2'b10);
    rd(12'h010, 32'h0, 2'b10);
  endtask

  task summarize();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1;
    repeat (4) @(posedge clk);
    reset_and_straps();
    outputs();
    inputs();
    irqs();
    lanes();
    unmapped();
    summarize();
  end

  // Watchdog against a hung handshake
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule
`default_nettype wire
